// >>> sdsc_defines.vh
// register offsets, reset values, field positions and timing counts for the sync and subcarrier bank
`ifndef SDSC_DEFINES_VH
`define SDSC_DEFINES_VH
`define SDSC_ADDR_TIMING 8'h8b
`define SDSC_ADDR_FREQ0 8'h8c
`define SDSC_ADDR_FREQ1 8'h8d
`define SDSC_ADDR_FREQ2 8'h8e
`define SDSC_ADDR_FREQ3 8'h8f
`define SDSC_ADDR_PHASE 8'h90
`define SDSC_ADDR_CC_EVEN_LO 8'h91
`define SDSC_ADDR_CC_EVEN_HI 8'h92
`define SDSC_ADDR_CC_ODD_LO 8'h93
`define SDSC_ADDR_CC_ODD_HI 8'h94
`define SDSC_ADDR_PED_ODD_A 8'h95
`define SDSC_ADDR_PED_ODD_B 8'h96
`define SDSC_ADDR_PED_EVEN_A 8'h97
`define SDSC_ADDR_CONTROL 8'hf0
`define SDSC_RST_TIMING 8'h00
`define SDSC_RST_FREQ0 8'h1f
`define SDSC_RST_FREQ1 8'h7c
`define SDSC_RST_FREQ2 8'hf0
`define SDSC_RST_FREQ3 8'h21
`define SDSC_RST_ZERO 8'h00
`define SDSC_RST_CONTROL 8'h00
`define SDSC_F_HSW_LSB 0
`define SDSC_F_HVD_LSB 2
`define SDSC_F_VSW_LSB 4
`define SDSC_F_VRE_BIT 4
`define SDSC_F_ADJ_LSB 6
`define SDSC_F_MASTER_BIT 0
`define SDSC_F_MODE_LSB 1
`define SDSC_F_PHLO_LSB 3
`define SDSC_W_1 8'd1
`define SDSC_W_4 8'd4
`define SDSC_W_16 8'd16
`define SDSC_W_128 8'd128
`define SDSC_D_0 8'd0
`define SDSC_D_4 8'd4
`define SDSC_D_8 8'd8
`define SDSC_D_18 8'd18
`define SDSC_EXTRA_US 32
`define SDSC_CLK_MHZ 100
`define SDSC_EXTRA_CYC (`SDSC_EXTRA_US * `SDSC_CLK_MHZ)
`define SDSC_FIRST_LINE 5'd10
`endif

// >>> sdsc_bank.v
// configuration bank with master-mode sync pulse generator and pedestal line decode
`include "sdsc_defines.vh"

// How it works
// - hsync width 1, 4, 16 cycles
// - hsync width code 11 gives 128
// - hsync to vsync delay 0,4,8,18
// - mode 1: timing bit 4 set adds 32 us to vsync rise
// - mode 2: vsync width 1,4,16,128
// - pixel data delayed 1 to 4 cycles, 1 in slave mode
// - four bytes form frequency word, low first
// - frequency bytes reset to ntsc values
// - phase byte holds bits 9:2, reset zero
// - phase low bits from control register top
// - two caption words, even and odd, zero
// - set bit disables that line's pedestal
// - odd disables cover lines 10 to 25
// - even disables cover lines 10 to 17
module sdsc_bank
#(
   parameter EXTRA_CYC = `SDSC_EXTRA_CYC
)
(
   // clock and reset
   input wire clk,
   input wire nrst,
   // register port
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   // upstream video
   input wire [15:0] pix_in,
   input wire line_start,
   input wire field_odd,
   input wire [9:0] line_num,
   // generated syncs and pixel data
   output reg hsync_out,
   output reg vsync_out,
   output reg [15:0] pix_out,
   // configuration outputs
   output wire [31:0] freq_word,
   output wire [9:0] phase_word,
   output wire [15:0] caption_even,
   output wire [15:0] caption_odd,
   output reg pedestal_off,
   output wire master_mode,
   output wire [1:0] timing_mode
);

   // ************************************
   // reset synchroniser
   // ************************************
   reg rst_s1;
   reg rst_s2;
   wire rst_n;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end
   assign rst_n = rst_s2;

   // ************************************
   // registers
   // ************************************
   reg [7:0] sync_pulse_timing;
   reg [7:0] subcarrier_freq_byte0;
   reg [7:0] subcarrier_freq_byte1;
   reg [7:0] subcarrier_freq_byte2;
   reg [7:0] subcarrier_freq_byte3;
   reg [7:0] subcarrier_phase_high;
   reg [7:0] caption_even_low;
   reg [7:0] caption_even_high;
   reg [7:0] caption_odd_low;
   reg [7:0] caption_odd_high;
   reg [7:0] pedestal_off_odd_a;
   reg [7:0] pedestal_off_odd_b;
   reg [7:0] pedestal_off_even_a;
   reg [7:0] encoder_control;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_pulse_timing <= `SDSC_RST_TIMING;
         subcarrier_freq_byte0 <= `SDSC_RST_FREQ0;
         subcarrier_freq_byte1 <= `SDSC_RST_FREQ1;
         subcarrier_freq_byte2 <= `SDSC_RST_FREQ2;
         subcarrier_freq_byte3 <= `SDSC_RST_FREQ3;
         subcarrier_phase_high <= `SDSC_RST_ZERO;
         caption_even_low <= `SDSC_RST_ZERO;
         caption_even_high <= `SDSC_RST_ZERO;
         caption_odd_low <= `SDSC_RST_ZERO;
         caption_odd_high <= `SDSC_RST_ZERO;
         pedestal_off_odd_a <= `SDSC_RST_ZERO;
         pedestal_off_odd_b <= `SDSC_RST_ZERO;
         pedestal_off_even_a <= `SDSC_RST_ZERO;
         encoder_control <= `SDSC_RST_CONTROL;
      end
      else if (wr)
      begin
         case (addr)
            `SDSC_ADDR_TIMING: sync_pulse_timing <= wdata;
            `SDSC_ADDR_FREQ0: subcarrier_freq_byte0 <= wdata;
            `SDSC_ADDR_FREQ1: subcarrier_freq_byte1 <= wdata;
            `SDSC_ADDR_FREQ2: subcarrier_freq_byte2 <= wdata;
            `SDSC_ADDR_FREQ3: subcarrier_freq_byte3 <= wdata;
            `SDSC_ADDR_PHASE: subcarrier_phase_high <= wdata;
            `SDSC_ADDR_CC_EVEN_LO: caption_even_low <= wdata;
            `SDSC_ADDR_CC_EVEN_HI: caption_even_high <= wdata;
            `SDSC_ADDR_CC_ODD_LO: caption_odd_low <= wdata;
            `SDSC_ADDR_CC_ODD_HI: caption_odd_high <= wdata;
            `SDSC_ADDR_PED_ODD_A: pedestal_off_odd_a <= wdata;
            `SDSC_ADDR_PED_ODD_B: pedestal_off_odd_b <= wdata;
            `SDSC_ADDR_PED_EVEN_A: pedestal_off_even_a <= wdata;
            `SDSC_ADDR_CONTROL: encoder_control <= wdata;
            default: ;
         endcase
      end
   end

   // ************************************
   // read port
   // ************************************
   reg [7:0] next_rdata;

   always @*
   begin
      next_rdata = 8'h00;
      case (addr)
         `SDSC_ADDR_TIMING: next_rdata = sync_pulse_timing;
         `SDSC_ADDR_FREQ0: next_rdata = subcarrier_freq_byte0;
         `SDSC_ADDR_FREQ1: next_rdata = subcarrier_freq_byte1;
         `SDSC_ADDR_FREQ2: next_rdata = subcarrier_freq_byte2;
         `SDSC_ADDR_FREQ3: next_rdata = subcarrier_freq_byte3;
         `SDSC_ADDR_PHASE: next_rdata = subcarrier_phase_high;
         `SDSC_ADDR_CC_EVEN_LO: next_rdata = caption_even_low;
         `SDSC_ADDR_CC_EVEN_HI: next_rdata = caption_even_high;
         `SDSC_ADDR_CC_ODD_LO: next_rdata = caption_odd_low;
         `SDSC_ADDR_CC_ODD_HI: next_rdata = caption_odd_high;
         `SDSC_ADDR_PED_ODD_A: next_rdata = pedestal_off_odd_a;
         `SDSC_ADDR_PED_ODD_B: next_rdata = pedestal_off_odd_b;
         `SDSC_ADDR_PED_EVEN_A: next_rdata = pedestal_off_even_a;
         `SDSC_ADDR_CONTROL: next_rdata = encoder_control;
         default: next_rdata = 8'h00;
      endcase
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end

   // ************************************
   // assembled configuration words
   // ************************************
   assign freq_word = {subcarrier_freq_byte3, subcarrier_freq_byte2,
      subcarrier_freq_byte1, subcarrier_freq_byte0};
   assign phase_word = {subcarrier_phase_high, encoder_control[7:6]};
   assign caption_even = {caption_even_high, caption_even_low};
   assign caption_odd = {caption_odd_high, caption_odd_low};
   assign master_mode = encoder_control[`SDSC_F_MASTER_BIT];
   assign timing_mode = encoder_control[`SDSC_F_MODE_LSB+1:`SDSC_F_MODE_LSB];

   // ************************************
   // sync timing decode
   // ************************************
   function [7:0] sdsc_width;
      input [1:0] code;
      begin
         case (code)
            2'b00: sdsc_width = `SDSC_W_1;
            2'b01: sdsc_width = `SDSC_W_4;
            2'b10: sdsc_width = `SDSC_W_16;
            default: sdsc_width = `SDSC_W_128;
         endcase
      end
   endfunction

   function [7:0] sdsc_delay;
      input [1:0] code;
      begin
         case (code)
            2'b00: sdsc_delay = `SDSC_D_0;
            2'b01: sdsc_delay = `SDSC_D_4;
            2'b10: sdsc_delay = `SDSC_D_8;
            default: sdsc_delay = `SDSC_D_18;
         endcase
      end
   endfunction

   wire [7:0] hs_width;
   wire [7:0] vs_width;
   wire [15:0] vs_delay;
   wire mode1;
   wire mode2;
   wire [15:0] extra;

   assign mode1 = (timing_mode == 2'b01);
   assign mode2 = (timing_mode == 2'b10);
   assign extra = EXTRA_CYC[15:0];
   assign hs_width = sdsc_width(sync_pulse_timing[1:0]);
   assign vs_width = mode2 ? sdsc_width(sync_pulse_timing[5:4]) : hs_width;
   assign vs_delay = {8'h00, sdsc_delay(sync_pulse_timing[3:2])} +
      ((mode1 && sync_pulse_timing[`SDSC_F_VRE_BIT]) ? extra : 16'h0000);

   // ************************************
   // sync pulse generator
   // ************************************
   reg [7:0] hs_cnt;
   reg [15:0] vd_cnt;
   reg [7:0] vs_cnt;
   reg vd_run;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hs_cnt <= 8'h00;
         vd_cnt <= 16'h0000;
         vs_cnt <= 8'h00;
         vd_run <= 1'b0;
         hsync_out <= 1'b0;
         vsync_out <= 1'b0;
      end
      else if (!master_mode)
      begin
         hs_cnt <= 8'h00;
         vd_cnt <= 16'h0000;
         vs_cnt <= 8'h00;
         vd_run <= 1'b0;
         hsync_out <= 1'b0;
         vsync_out <= 1'b0;
      end
      else
      begin
         if (line_start)
         begin
            hs_cnt <= hs_width - 8'd1;
            hsync_out <= 1'b1;
         end
         else if (hs_cnt != 8'h00)
            hs_cnt <= hs_cnt - 8'd1;
         else
            hsync_out <= 1'b0;
         if (line_start && line_num == 10'd0)
         begin
            if (vs_delay == 16'h0000)
            begin
               vsync_out <= 1'b1;
               vs_cnt <= vs_width - 8'd1;
            end
            else
            begin
               vd_run <= 1'b1;
               vd_cnt <= vs_delay - 16'd1;
            end
         end
         else if (vd_run && vd_cnt != 16'h0000)
            vd_cnt <= vd_cnt - 16'd1;
         else if (vd_run)
         begin
            vd_run <= 1'b0;
            vsync_out <= 1'b1;
            vs_cnt <= vs_width - 8'd1;
         end
         else if (vs_cnt != 8'h00)
            vs_cnt <= vs_cnt - 8'd1;
         else
            vsync_out <= 1'b0;
      end
   end

   // ************************************
   // pixel alignment
   // ************************************
   reg [15:0] pix_d1;
   reg [15:0] pix_d2;
   reg [15:0] pix_d3;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pix_d1 <= 16'h0000;
         pix_d2 <= 16'h0000;
         pix_d3 <= 16'h0000;
         pix_out <= 16'h0000;
      end
      else
      begin
         pix_d1 <= pix_in;
         pix_d2 <= pix_d1;
         pix_d3 <= pix_d2;
         case (master_mode ? sync_pulse_timing[7:6] : 2'b00)
            2'b00: pix_out <= pix_in;
            2'b01: pix_out <= pix_d1;
            2'b10: pix_out <= pix_d2;
            default: pix_out <= pix_d3;
         endcase
      end
   end

   // ************************************
   // pedestal line decode
   // ************************************
   wire [9:0] rel;
   wire [23:0] ped_map;

   assign rel = line_num - {5'd0, `SDSC_FIRST_LINE};
   assign ped_map = field_odd ? {8'h00, pedestal_off_odd_b, pedestal_off_odd_a}
      : {16'h0000, pedestal_off_even_a};

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pedestal_off <= 1'b0;
      else if (line_num >= {5'd0, `SDSC_FIRST_LINE} && rel < 10'd16)
         pedestal_off <= ped_map[rel[3:0]];
      else
         pedestal_off <= 1'b0;
   end

endmodule

// >>> sdsc_properties.sv
// concurrent checks on the ports of the sync and subcarrier bank
module sdsc_properties
(
   // clock, reset and register port
   input wire clk,
   input wire nrst,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   // video and configuration
   input wire [15:0] pix_in,
   input wire field_odd,
   input wire [9:0] line_num,
   input wire hsync_out,
   input wire vsync_out,
   input wire [15:0] pix_out,
   input wire [31:0] freq_word,
   input wire [9:0] phase_word,
   input wire [15:0] caption_odd,
   input wire pedestal_off,
   input wire master_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [7:0] tim, pa, pb, pe, hs_n, hs_w, age;
   logic ped;
   // shadow copies and pulse counter
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tim <= 8'h00;
         pa <= 8'h00;
         pb <= 8'h00;
         pe <= 8'h00;
         age <= 8'h00;
         hs_n <= 8'h00;
      end
      else
      begin
         if (wr && addr == 8'h8b) tim <= wdata;
         if (wr && addr == 8'h95) pa <= wdata;
         if (wr && addr == 8'h96) pb <= wdata;
         if (wr && addr == 8'h97) pe <= wdata;
         age <= (wr && addr == 8'h8b) ? 8'h00 : (age == 8'hff ? age : age + 8'h01);
         hs_n <= hsync_out ? hs_n + 8'h01 : 8'h00;
      end
   end
   assign hs_w = tim[1:0] == 2'd0 ? 8'd1 : tim[1:0] == 2'd1 ? 8'd4 :
                 tim[1:0] == 2'd2 ? 8'd16 : 8'd128;
   always_comb
   begin
      ped = 1'b0;
      if (line_num >= 10 && line_num <= 17) ped = field_odd ? pa[line_num - 10] : pe[line_num - 10];
      if (field_odd && line_num >= 18 && line_num <= 25) ped = pb[line_num - 18];
   end
   AST_FREQ_LO: assert property (wr && addr == 8'h8c |=> freq_word[7:0] == $past(wdata))
      else $error("low frequency byte not taken");
   AST_FREQ_HI: assert property (wr && addr == 8'h8f |=> freq_word[31:24] == $past(wdata))
      else $error("high frequency byte not taken");
   AST_RD_FREQ: assert property (rd && addr == 8'h8f |=> rdata == $past(freq_word[31:24]))
      else $error("frequency byte read back wrong");
   AST_PHASE_HI: assert property (wr && addr == 8'h90 |=> phase_word[9:2] == $past(wdata))
      else $error("upper phase bits wrong");
   AST_PHASE_LO: assert property (wr && addr == 8'hf0 |=> phase_word[1:0] == $past(wdata[7:6]))
      else $error("lower phase bits wrong");
   AST_CAPTION: assert property (wr && addr == 8'h93 |=> caption_odd[7:0] == $past(wdata))
      else $error("odd caption low byte wrong");
   AST_PED: assert property (pedestal_off == $past(ped))
      else $error("pedestal disable wrong for line");
   AST_HS_WIDTH: assert property ($fell(hsync_out) && age > hs_n |-> hs_n == hs_w)
      else $error("horizontal sync width wrong");
   AST_SLAVE: assert property (!master_mode [*2] |-> !hsync_out && !vsync_out)
      else $error("sync driven in slave mode");
   AST_PIX0: assert property (age > 8 && tim[7:6] == 2'd0 |-> pix_out == $past(pix_in))
      else $error("pixel delay wrong for adjust 0");
   AST_PIX3: assert property (age > 8 && tim[7:6] == 2'd3 |-> pix_out == $past(pix_in, 4))
      else $error("pixel delay wrong for adjust 3");
endmodule

// >>> sdsc_video_src.sv
// upstream video source model: pixel counter, line pulses, line number, field
module sdsc_video_src
#(
   parameter LEN = 200,
   parameter NL = 28
)
(
   // clock, reset and video out
   input wire clk,
   input wire nrst,
   output logic [15:0] pix,
   output logic ls,
   output logic fo,
   output logic [9:0] ln
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pix <= 16'h0000;
         cnt <= 8'h00;
         ls <= 1'b0;
         fo <= 1'b1;
         ln <= 10'h000;
      end
      else
      begin
         pix <= pix + 16'h0001;
         cnt <= (cnt == LEN - 1) ? 8'h00 : cnt + 8'h01;
         ls <= (cnt == LEN - 1);
         if (cnt == LEN - 1) ln <= (ln == NL - 1) ? 10'h000 : ln + 10'h001;
         if (cnt == LEN - 1 && ln == NL - 1) fo <= ~fo;
      end
   end
endmodule

// >>> sdsc_bank_tb.sv
// self-checking bench for the sync and subcarrier bank
module sdsc_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam XC = 20;
   localparam logic [7:0] PA = 8'h81, PB = 8'h42, PE = 8'h5a;
   logic clk = 0, nrst = 0, wr = 0, rd = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
   logic [15:0] pix_in, pix_out, caption_even, caption_odd;
   logic line_start, field_odd, hsync_out, vsync_out, pedestal_off, master_mode;
   logic [9:0] line_num, phase_word;
   logic [31:0] freq_word;
   logic [1:0] timing_mode;
   int err_total = 0, n_checks = 0, c, ch, cv, w, i;
   logic [7:0] ra [0:13] = '{8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'h90, 8'h91, 8'h92, 8'h93,
      8'h94, 8'h95, 8'h96, 8'h97, 8'hf0};
   logic [7:0] rv [0:13] = '{8'h00, 8'h1f, 8'h7c, 8'hf0, 8'h21, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   int dt [0:3] = '{0, 4, 8, 18};
   int wt [0:3] = '{1, 4, 16, 128};
   always #5 clk = ~clk;
   sdsc_bank #(.EXTRA_CYC(XC)) dut (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .pix_in,
      .line_start, .field_odd, .line_num, .hsync_out, .vsync_out, .pix_out, .freq_word,
      .phase_word, .caption_even, .caption_odd, .pedestal_off, .master_mode, .timing_mode);
   sdsc_video_src src (.clk, .nrst, .pix(pix_in), .ls(line_start), .fo(field_odd), .ln(line_num));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task wait_ls;
      do
      begin
         @(posedge clk);
         #1;
      end
      while (line_start !== 1'b1);
   endtask
   function automatic logic pexp(input logic f, input logic [9:0] l);
      pexp = 1'b0;
      if (l >= 10 && l <= 17) pexp = f ? PA[l - 10] : PE[l - 10];
      if (f && l >= 18 && l <= 25) pexp = PB[l - 18];
   endfunction
   task sync_case(input logic [1:0] m, input logic [7:0] t, input int dv, input int wv);
      wr_reg(8'h8b, t);
      wr_reg(8'hf0, {5'h00, m, 1'b1});
      do wait_ls; while (line_num !== 10'd0);
      ch = 0;
      cv = 0;
      w = 0;
      for (c = 1; c < 400; c++)
      begin
         @(posedge clk);
         #1;
         if (hsync_out === 1'b1 && ch == 0) ch = c;
         if (vsync_out === 1'b1 && cv == 0) cv = c;
         if (vsync_out === 1'b1) w++;
      end
      chk(cv - ch, dv);
      chk(w, wv);
      chk(pix_out, 16'(pix_in - 16'd1 - t[7:6]));
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #900000;
      err_total++;
      results;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      for (i = 0; i < 14; i++)
      begin
         rd_reg(ra[i], d);
         chk(d, rv[i]);
      end
      for (i = 0; i < 14; i++) wr_reg(ra[i], ra[i] ^ 8'ha5);
      wr_reg(8'h80, 8'hff);
      for (i = 0; i < 14; i++)
      begin
         rd_reg(ra[i], d);
         chk(d, ra[i] ^ 8'ha5);
      end
      rd_reg(8'h80, d);
      chk(d, 8'h00);
      chk(freq_word, {8'h8f, 8'h8e, 8'h8d, 8'h8c} ^ {4{8'ha5}});
      chk(phase_word, {8'h90 ^ 8'ha5, 2'b01});
      chk(caption_even, {8'h92, 8'h91} ^ 16'ha5a5);
      chk(caption_odd, {8'h94, 8'h93} ^ 16'ha5a5);
      chk({master_mode, timing_mode}, 3'b110);
      $display("test registers done");
      wr_reg(8'h95, PA);
      wr_reg(8'h96, PB);
      wr_reg(8'h97, PE);
      repeat (56)
      begin
         wait_ls;
         @(posedge clk);
         #1 chk(pedestal_off, pexp(field_odd, line_num));
      end
      $display("test pedestal done");
      for (i = 0; i < 4; i++) sync_case(2'd0, {i[1:0], 2'b00, i[1:0], i[1:0]}, dt[i], wt[i]);
      sync_case(2'd1, 8'h19, 8 + XC, 4);
      for (i = 0; i < 4; i++) sync_case(2'd2, {2'b00, i[1:0], 4'b1100}, 18, wt[i]);
      $display("test syncs done");
      results;
   end
endmodule
bind sdsc_bank sdsc_properties chk_i (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .pix_in,
   .field_odd, .line_num, .hsync_out, .vsync_out, .pix_out, .freq_word, .phase_word,
   .caption_odd, .pedestal_off, .master_mode);
